// File: include/epl_pkg.sv
// package for the external interrupt request pin logic
// assumes an AXI4-Lite master with 32-bit data drives the register slave
package epl_pkg;

    // ****************************************************************
    // register map
    // ****************************************************************
    localparam int unsigned EPL_ADDR_W = 4;
    localparam logic [EPL_ADDR_W-1:0] EPL_PIN_INT_SC_OFFSET = 4'h0;

    // ****************************************************************
    // field positions of pin_interrupt_status_control
    // ****************************************************************
    localparam int unsigned EPL_MODE_BIT = 0;
    localparam int unsigned EPL_IEN_BIT = 1;
    localparam int unsigned EPL_ACK_BIT = 2;
    localparam int unsigned EPL_FLAG_BIT = 3;
    localparam int unsigned EPL_PEN_BIT = 4;
    localparam int unsigned EPL_POL_BIT = 5;

    // ****************************************************************
    // reset values
    // ****************************************************************
    localparam logic EPL_MODE_RST = 1'b0;
    localparam logic EPL_IEN_RST = 1'b0;
    localparam logic EPL_PEN_RST = 1'b0;
    localparam logic EPL_POL_RST = 1'b0;
    localparam logic EPL_FLAG_RST = 1'b0;

    // ****************************************************************
    // AXI responses
    // ****************************************************************
    localparam logic [1:0] EPL_RESP_OKAY = 2'h0;
    localparam logic [1:0] EPL_RESP_SLVERR = 2'h2;

endpackage

// File: hdl/epl_detect.sv
// edge and level detector for the interrupt request pin
// assumes the pin is asynchronous; it is synchronised here with two flip-flops
`timescale 1ns/10ps
`default_nettype none
module epl_detect
    import epl_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // pin and configuration
    input wire logic pin_in,
    input wire logic pin_function_enable,
    input wire logic edge_polarity_select,
    input wire logic edge_level_mode,
    // results
    output logic event_detect,
    output logic level_asserted
);

    typedef struct packed {
        logic sync1;
        logic sync2;
        logic prev;
    } epl_det_s;

    epl_det_s st_q;
    epl_det_s st_d;
    logic asserted_now;
    logic asserted_prev;

    always_comb
    begin
        st_d = st_q;
        st_d.sync1 = pin_in;
        st_d.sync2 = st_q.sync1;
        st_d.prev = st_q.sync2;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= '0;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // polarity folds rising and falling into one "asserted" sense
    assign asserted_now = st_q.sync2 ~^ edge_polarity_select; // R5
    assign asserted_prev = st_q.prev ~^ edge_polarity_select;

    // level events only in edge-and-level mode; nothing while disabled
    assign event_detect = pin_function_enable
        & ((asserted_now & ~asserted_prev) | (edge_level_mode & asserted_now)); // R12 R6
    assign level_asserted = pin_function_enable & edge_level_mode & asserted_now; // R10

endmodule
`default_nettype wire

// File: hdl/epl_top.sv
// external interrupt request pin logic with its AXI4-Lite register slave
// assumes one write and one read at most in flight; pin is asynchronous
`timescale 1ns/10ps
`default_nettype none
// Contract
// R1: bits 7 and 6 of the status and control register read zero and ignore writes.
// R2: bit 4 is a read/write pin enable that gates all event detection.
// R3: the pull resistor is on exactly while the pin enable is set.
// R4: the resistor is a pulldown when enabled for rising edges, otherwise a pullup.
// R5: bit 5 selects falling/low (0) or rising/high (1) as the asserted sense.
// R6: bit 0 selects edge-only (0) or edge-and-level (1) detection.
// R7: bit 3 is a read-only flag set when an event is detected.
// R8: writing 1 to bit 2 clears the flag.
// R9: writing 0 to bit 2 does nothing and bit 2 always reads zero.
// R10: in edge-and-level mode the flag cannot be cleared while the pin stays asserted.
// R11: the interrupt request is high while the flag and bit 1 enable are both set.
// R12: the pin is synchronised with two flip-flops and edges come from consecutive samples.
// R13: an event in the same cycle as an acknowledge leaves the flag set.
module epl_top
    import epl_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // write address channel
    input wire logic [EPL_ADDR_W-1:0] s_axi_awaddr,
    input wire logic [2:0] s_axi_awprot,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // write data channel
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // write response channel
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // read address channel
    input wire logic [EPL_ADDR_W-1:0] s_axi_araddr,
    input wire logic [2:0] s_axi_arprot,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // read data channel
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // pin side
    input wire logic pin_in,
    output logic pull_enable,
    output logic pull_down_select,
    // interrupt request
    output logic irq_request
);

    // ****************************************************************
    // state
    // ****************************************************************
    typedef struct packed {
        logic awready;
        logic wready;
        logic aw_held;
        logic w_held;
        logic [EPL_ADDR_W-1:0] awaddr;
        logic [7:0] wbyte;
        logic wbyte_en;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic mode;
        logic ien;
        logic pen;
        logic pol;
        logic flag;
        logic pull_en;
        logic pull_dn;
        logic irq;
    } epl_top_s;

    epl_top_s st_q;
    epl_top_s st_d;
    logic event_detect;
    logic level_asserted;

    function automatic logic hit(input logic [EPL_ADDR_W-1:0] addr);
        hit = (addr[EPL_ADDR_W-1:2] == EPL_PIN_INT_SC_OFFSET[EPL_ADDR_W-1:2]);
    endfunction

    // ****************************************************************
    // detector
    // ****************************************************************
    epl_detect u_detect (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin_in(pin_in),
        .pin_function_enable(st_q.pen),
        .edge_polarity_select(st_q.pol),
        .edge_level_mode(st_q.mode),
        .event_detect(event_detect),
        .level_asserted(level_asserted)
    );

    // ****************************************************************
    // next state
    // ****************************************************************
    always_comb
    begin
        logic do_write;
        logic ack;
        do_write = 1'b0;
        ack = 1'b0;
        st_d = st_q;

        // capture address and data independently, in either order
        if (s_axi_awvalid && st_q.awready)
        begin
            st_d.awaddr = s_axi_awaddr;
            st_d.aw_held = 1'b1;
            st_d.awready = 1'b0;
        end
        if (s_axi_wvalid && st_q.wready)
        begin
            st_d.wbyte = s_axi_wdata[7:0];
            st_d.wbyte_en = s_axi_wstrb[0];
            st_d.w_held = 1'b1;
            st_d.wready = 1'b0;
        end

        // commit once both halves are held and no response is pending
        if (st_q.aw_held && st_q.w_held && !st_q.bvalid)
        begin
            st_d.aw_held = 1'b0;
            st_d.w_held = 1'b0;
            st_d.bvalid = 1'b1;
            if (hit(st_q.awaddr))
            begin
                st_d.bresp = EPL_RESP_OKAY;
                do_write = st_q.wbyte_en;
            end
            else
            begin
                st_d.bresp = EPL_RESP_SLVERR;
            end
        end
        if (st_q.bvalid && s_axi_bready)
        begin
            st_d.bvalid = 1'b0;
            st_d.awready = 1'b1;
            st_d.wready = 1'b1;
        end

        if (do_write)
        begin
            // bits 7:6 and the flag bit are not stored
            st_d.mode = st_q.wbyte[EPL_MODE_BIT]; // R6 R1
            st_d.ien = st_q.wbyte[EPL_IEN_BIT];
            st_d.pen = st_q.wbyte[EPL_PEN_BIT]; // R2
            st_d.pol = st_q.wbyte[EPL_POL_BIT]; // R5
            ack = st_q.wbyte[EPL_ACK_BIT]; // R8 R9
        end

        // set beats clear; a held level re-asserts the flag as well
        if (event_detect || level_asserted)
        begin
            st_d.flag = 1'b1; // R7 R13 R10
        end
        else if (ack)
        begin
            st_d.flag = 1'b0; // R8
        end

        // read channel
        if (s_axi_arvalid && st_q.arready)
        begin
            st_d.arready = 1'b0;
            st_d.rvalid = 1'b1;
            st_d.rdata = '0;
            if (hit(s_axi_araddr))
            begin
                st_d.rresp = EPL_RESP_OKAY;
                st_d.rdata[EPL_MODE_BIT] = st_q.mode;
                st_d.rdata[EPL_IEN_BIT] = st_q.ien;
                st_d.rdata[EPL_FLAG_BIT] = st_q.flag;
                st_d.rdata[EPL_PEN_BIT] = st_q.pen;
                st_d.rdata[EPL_POL_BIT] = st_q.pol;
                // acknowledge and bits 7:6 stay zero
                st_d.rdata[EPL_ACK_BIT] = 1'b0; // R9 R1
            end
            else
            begin
                st_d.rresp = EPL_RESP_SLVERR;
            end
        end
        if (st_q.rvalid && s_axi_rready)
        begin
            st_d.rvalid = 1'b0;
            st_d.arready = 1'b1;
        end

        // pin outputs follow the registered configuration one cycle later
        st_d.pull_en = st_q.pen; // R3
        st_d.pull_dn = st_q.pen & st_q.pol; // R4
        st_d.irq = st_q.flag & st_q.ien; // R11
    end

    // ****************************************************************
    // registers
    // ****************************************************************
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            st_q <= '0;
            st_q.awready <= 1'b1;
            st_q.wready <= 1'b1;
            st_q.arready <= 1'b1;
            st_q.mode <= EPL_MODE_RST;
            st_q.ien <= EPL_IEN_RST;
            st_q.pen <= EPL_PEN_RST;
            st_q.pol <= EPL_POL_RST;
            st_q.flag <= EPL_FLAG_RST;
        end
        else
        begin
            st_q <= st_d;
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign s_axi_awready = st_q.awready;
    assign s_axi_wready = st_q.wready;
    assign s_axi_bvalid = st_q.bvalid;
    assign s_axi_bresp = st_q.bresp;
    assign s_axi_arready = st_q.arready;
    assign s_axi_rvalid = st_q.rvalid;
    assign s_axi_rdata = st_q.rdata;
    assign s_axi_rresp = st_q.rresp;
    assign pull_enable = st_q.pull_en;
    assign pull_down_select = st_q.pull_dn;
    assign irq_request = st_q.irq;

endmodule
`default_nettype wire

// File: tb/epl_props.sv
// checker for the pin logic: register effects, flag and interrupt request
// assumes it sees only epl_top ports; bound after the module
`timescale 1ns/10ps
`default_nettype none
module epl_props
    import epl_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    // pin and request
    input wire logic pin_in,
    input wire logic pull_enable,
    input wire logic pull_down_select,
    input wire logic irq_request
);
    // ****************************************
    // shadow of the last committed write
    // ****************************************
    logic bv_q;
    logic ws_q;
    logic pin_q;
    logic [7:0] wd_q;
    logic [7:0] ctl_q;
    logic [2:0] quiet_q;
    logic [2:0] since_q;
    wire commit = s_axi_bvalid & ~bv_q & (s_axi_bresp == EPL_RESP_OKAY) & ws_q;
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            {bv_q, ws_q, pin_q, wd_q, ctl_q, quiet_q, since_q} <= '0;
        end
        else
        begin
            bv_q <= s_axi_bvalid;
            pin_q <= pin_in;
            if (s_axi_wvalid && s_axi_wready)
                {ws_q, wd_q} <= {s_axi_wstrb[0], s_axi_wdata[7:0]};
            quiet_q <= (pin_in != pin_q) ? 3'h0 : quiet_q + {2'h0, quiet_q != 3'h7};
            since_q <= commit ? 3'h0 : since_q + {2'h0, since_q != 3'h7};
            if (commit)
                ctl_q <= wd_q;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_rsvd_zero: assert property (
        s_axi_rvalid |-> s_axi_rdata[31:6] == 26'h0 && !s_axi_rdata[2]) else $error("reserved bits nonzero");
    a_pull_config: assert property (
        commit |=> pull_enable == wd_q[4] && pull_down_select == (wd_q[4] && wd_q[5])) else $error("pull wrong");
    a_ack_clears: assert property (
        commit && wd_q[2] && !wd_q[0] && quiet_q == 3'h7 |=> !irq_request) else $error("ack did not clear");
    a_level_holds: assert property (
        commit && wd_q[0] && wd_q[1] && wd_q[4] && pin_in == wd_q[5] && quiet_q == 3'h7
        |-> ##[1:5] irq_request ##1 irq_request) else $error("level flag lost");
    a_edge_sets: assert property (
        ctl_q[4] && ctl_q[1] && since_q == 3'h7 && pin_in != pin_q && pin_in == ctl_q[5]
        |-> ##[1:6] irq_request) else $error("edge missed");
    a_edge_only: assert property (
        ctl_q[4] && !ctl_q[0] && since_q == 3'h7 && quiet_q == 3'h7 && !commit && !irq_request
        |=> !irq_request) else $error("steady pin raised request");
    a_disabled_quiet: assert property (
        !ctl_q[4] && since_q == 3'h7 && !commit |=> $stable(irq_request)) else $error("event while disabled");
    a_irq_masked: assert property (
        commit && !wd_q[1] |=> !irq_request) else $error("masked request high");
    a_reset_clear: assert property (@(posedge aclk) disable iff (1'b0)
        !aresetn |=> !irq_request && !pull_enable && !s_axi_bvalid) else $error("reset state wrong");
    c_commit: cover property (commit && wd_q[2]);
    c_irq: cover property ($rose(irq_request));
    c_level: cover property (ctl_q[0] && irq_request);
endmodule
bind epl_top epl_props u_props (.*);
`default_nettype wire

// File: tb/epl_pin_src.sv
// external source on the request pin
// assumes the bench says when it drives; otherwise pull or floating line shows
`timescale 1ns/10ps
`default_nettype none
module epl_pin_src
(
    // clock and control
    input wire logic aclk,
    input wire logic drive_en,
    input wire logic drive_val,
    // device pull
    input wire logic pull_enable,
    input wire logic pull_down_select,
    // pin
    output var logic pin
);
    initial pin = 1'b1;
    // a floating line toggles so it never passes for a clean level
    always @(posedge aclk)
        pin <= drive_en ? drive_val : (pull_enable ? ~pull_down_select : ~pin);
endmodule
`default_nettype wire

// File: tb/tb_top.sv
// self-checking bench for the pin logic
// assumes epl_top, epl_pin_src and the bound checker
`timescale 1ns/10ps
`default_nettype none
module tb_top import epl_pkg::*; ;
    localparam logic [EPL_ADDR_W-1:0] RG = EPL_PIN_INT_SC_OFFSET;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [EPL_ADDR_W-1:0] s_axi_awaddr = '0;
    logic [EPL_ADDR_W-1:0] s_axi_araddr = '0;
    logic [2:0] s_axi_awprot = 3'h0;
    logic [2:0] s_axi_arprot = 3'h0;
    logic [31:0] s_axi_wdata = '0;
    logic [3:0] s_axi_wstrb = '0;
    logic s_axi_awvalid = 1'b0;
    logic s_axi_wvalid = 1'b0;
    logic s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0;
    logic s_axi_rready = 1'b0;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_rdata;
    logic pin_in, pull_enable, pull_down_select, irq_request;
    logic drv_en = 1'b0;
    logic drv_val = 1'b0;
    int n_mismatch = 0;
    int num_checks = 0;
    epl_top dut (.*);
    epl_pin_src u_src (.aclk, .drive_en(drv_en), .drive_val(drv_val), .pull_enable, .pull_down_select, .pin(pin_in));
    initial
    begin
        forever #10 aclk = ~aclk;
    end
    // ****************************************
    // shared tasks
    // ****************************************
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic complete_run();
        if (n_mismatch == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask
    task automatic hang();
        n_mismatch++;
        complete_run();
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic s, output logic [1:0] r);
        bit done;
        done = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= {24'h0, d};
        s_axi_wstrb <= {3'h0, s};
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 40 && !done; i++)
        begin
            @(posedge aclk);
            if (s_axi_awready)
                s_axi_awvalid <= 1'b0;
            if (s_axi_wready)
                s_axi_wvalid <= 1'b0;
            // bready stays high between writes so it is never dropped and raised in one step
            if (s_axi_bvalid)
            begin
                r = s_axi_bresp;
                done = 1;
            end
        end
        if (!done)
            hang();
    endtask
    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        bit done;
        done = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 40 && !done; i++)
        begin
            @(posedge aclk);
            if (s_axi_arready)
                s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid)
            begin
                {d, r} = {s_axi_rdata, s_axi_rresp};
                done = 1;
            end
        end
        if (!done)
            hang();
    endtask
    task automatic pin(input logic v);
        drv_en <= 1'b1;
        drv_val <= v;
        @(posedge aclk);
    endtask
    task automatic wait_irq();
        for (int i = 0; i < 10 && irq_request !== 1'b1; i++)
            @(posedge aclk);
        if (irq_request !== 1'b1)
            hang();
    endtask
    // ****************************************
    // scenarios
    // ****************************************
    task automatic t_regs();
        logic [31:0] d;
        logic [1:0] r;
        pin(1'b0);
        rd(RG, d, r);
        chk(d, 32'h0);
        wr(RG, 8'hFF, 1'b1, r);
        chk(r, EPL_RESP_OKAY);
        rd(RG, d, r);
        chk(d, 32'h33);
        chk(r, EPL_RESP_OKAY);
        chk({pull_enable, pull_down_select}, 2'h3);
        // a write without its byte strobe answers but leaves the register alone
        wr(RG, 8'h00, 1'b0, r);
        chk(r, EPL_RESP_OKAY);
        rd(RG, d, r);
        chk(d, 32'h33);
        wr(RG, 8'h10, 1'b1, r);
        rd(RG, d, r);
        chk(d, 32'h10);
        chk({pull_enable, pull_down_select}, 2'h2);
        wr(4'h4, 8'hFF, 1'b1, r);
        chk(r, EPL_RESP_SLVERR);
        rd(4'h4, d, r);
        chk(d, 32'h0);
        chk(r, EPL_RESP_SLVERR);
        wr(RG, 8'h00, 1'b1, r);
        rd(RG, d, r);
        chk(pull_enable, 1'b0);
    endtask
    task automatic t_edge(input logic p);
        logic [31:0] d;
        logic [1:0] r;
        pin(~p);
        wr(RG, {2'b00, p, 5'b10110}, 1'b1, r);
        repeat (4) @(posedge aclk);
        rd(RG, d, r);
        chk(d, {26'h0, p, 5'b10010});
        chk(irq_request, 1'b0);
        pin(p);
        wait_irq();
        chk(irq_request, 1'b1);
        wr(RG, {2'b00, p, 5'b10010}, 1'b1, r);
        rd(RG, d, r);
        chk(d[3], 1'b1);
        wr(RG, {2'b00, p, 5'b10000}, 1'b1, r);
        rd(RG, d, r);
        chk({d[3], irq_request}, 2'h2);
        wr(RG, {2'b00, p, 5'b10110}, 1'b1, r);
        rd(RG, d, r);
        chk({d[3], irq_request}, 2'h0);
        // edge timed so that its flag set lands on the acknowledge commit edge
        pin(~p);
        repeat (3) @(posedge aclk);
        pin(p);
        @(posedge aclk);
        wr(RG, {2'b00, p, 5'b10110}, 1'b1, r);
        rd(RG, d, r);
        chk(d[3], 1'b1);
        wr(RG, {2'b00, p, 5'b10110}, 1'b1, r);
        rd(RG, d, r);
        chk(d[3], 1'b0);
        pin(~p);
        wr(RG, {2'b00, p, 5'b00010}, 1'b1, r);
        pin(p);
        repeat (6) @(posedge aclk);
        rd(RG, d, r);
        chk({d[3], irq_request, pull_enable}, 3'h0);
    endtask
    task automatic t_level(input logic p);
        logic [31:0] d;
        logic [1:0] r;
        wr(RG, {2'b00, p, 5'b10111}, 1'b1, r);
        wait_irq();
        wr(RG, {2'b00, p, 5'b10111}, 1'b1, r);
        rd(RG, d, r);
        chk({d[3], irq_request}, 2'h3);
        pin(~p);
        repeat (4) @(posedge aclk);
        wr(RG, {2'b00, p, 5'b10111}, 1'b1, r);
        rd(RG, d, r);
        chk(d, {26'h0, p, 5'b10011});
        wr(RG, 8'h00, 1'b1, r);
    endtask
    initial
    begin
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        t_regs();
        for (int p = 0; p < 2; p++)
        begin
            t_edge(p[0]);
            t_level(p[0]);
        end
        complete_run();
    end
endmodule
`default_nettype wire
